// *** common/ocd_defs.svh ***
// Constants for the setup word decoder: offsets, fields, codes, times.
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
`define OCD_CLK_MHZ 125
`define OCD_HOLD_LONG_US 18000
`define OCD_HOLD_SHORT_US 1125
`define OCD_CNT_W 22
`define OCD_ADDR_W 5
`define OCD_REG_SMALL 5'h00
`define OCD_REG_LARGE 5'h04
`define OCD_REG_CTRL 5'h08
`define OCD_REG_STAT 5'h0C
`define OCD_SMALL_ONES 32'h0000FFC0
`define OCD_LARGE_ONES 32'h00000F80
`define OCD_SMALL_RST 6'h3F
`define OCD_LARGE_RST 7'h7F
`define OCD_S_SPD 5
`define OCD_S_RST 4
`define OCD_S_CP 3
`define OCD_S_WDT 2
`define OCD_S_OSC_HI 1
`define OCD_L_SPD 6
`define OCD_L_RST 5
`define OCD_L_CP 4
`define OCD_L_WDT 3
`define OCD_L_OSC_HI 2
`define OCD_CTRL_VAR 0
`define OCD_CTRL_RESTART 1
`define OCD_SOSC_LP 3'h0
`define OCD_SOSC_XT 3'h1
`define OCD_SOSC_INT 3'h2
`define OCD_SOSC_ERC 3'h3
`define OCD_LOSC_LP 3'h0
`define OCD_LOSC_XT 3'h1
`define OCD_LOSC_HS 3'h2
`define OCD_LOSC_EC 3'h3
`define OCD_LOSC_INT 3'h4
`define OCD_LOSC_INTCK 3'h5
`define OCD_LOSC_ERC 3'h6
`define OCD_LOSC_ERCCK 3'h7
`define OCD_RESP_OKAY 2'h0
`define OCD_RESP_SLVERR 2'h2
`endif

// *** common/ocd_pkg.sv ***
// Types shared by the setup word decoder.
package ocd_pkg;
`include "ocd_defs.svh"
  typedef enum logic [2:0] {
    OCD_OSC_LP = 3'h0,
    OCD_OSC_XT = 3'h1,
    OCD_OSC_HS = 3'h2,
    OCD_OSC_EC = 3'h3,
    OCD_OSC_INT = 3'h4,
    OCD_OSC_ERC = 3'h5
  } ocd_osc_t;
  typedef enum logic [1:0] {
    OCD_ST_HOLD = 2'h0,
    OCD_ST_RUN = 2'h1,
    OCD_ST_RESTART = 2'h3
  } ocd_hold_st_t;
  typedef struct packed {
    logic speed_8mhz;
    logic ext_reset_en;
    logic protect_on;
    logic watchdog_on;
    ocd_osc_t osc_src;
    logic instruction_clock_output_on;
    logic long_hold;
  } ocd_cfg_t;
  typedef struct packed {
    ocd_hold_st_t st;
    logic [`OCD_CNT_W-1:0] cnt;
    logic [5:0] small_w;
    logic [6:0] large_w;
    logic variant;
    ocd_cfg_t cfg;
    logic hold_active;
    logic device_reset;
    logic port_in;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [`OCD_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`OCD_ADDR_W-1:0] raddr;
  } ocd_state_t;
endpackage : ocd_pkg

// *** rtl/ocd_top.sv ***
// Setup word decoder with start-up hold timer behind an AXI4-Lite slave.
// What this block does
// - Unused upper setup word bits read as one: 15-6 small, 11-7 large.
// - Speed select one gives 8 MHz internal RC, zero gives 4 MHz.
// - Reset-pin enable makes pin the low reset; else port input, no reset.
// - Read protection bit one disables protection, zero enables it.
// - Small part: code 00 low-power crystal, 01 standard crystal, 18 ms hold.
// - Small part: code 10 internal RC, 11 outboard RC, 1.125 ms hold.
// - Large part: code 100 internal RC, port pin, 1.125 ms hold.
// - Large part: code 101 internal RC with clock out, 1.125 ms hold.
// - Large part: code 110 outboard RC, port pin, 1.125 ms hold.
// - Small part fields: speed 5, reset pin 4, protect 3, watchdog 2, osc 1-0.
// - Start-up hold keeps the device in reset until its interval expires.
// - Only the setup word bit can switch the watchdog off.
`timescale 1ns/1ps
`include "ocd_defs.svh"
module ocd_top
  import ocd_pkg::*;
#(
  parameter int LONG_HOLD_CYC = `OCD_HOLD_LONG_US * `OCD_CLK_MHZ,
  parameter int SHORT_HOLD_CYC = `OCD_HOLD_SHORT_US * `OCD_CLK_MHZ
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Write address channel.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`OCD_ADDR_W-1:0] s_axi_awaddr,
  // Write data channel.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Write response channel.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read address channel.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`OCD_ADDR_W-1:0] s_axi_araddr,
  // Read data channel.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Shared reset and port pin, active low when used as reset.
  input wire logic external_reset_input_n,
  // Decoded setup and reset control.
  output ocd_cfg_t cfg,
  output logic hold_active,
  output logic device_reset,
  output logic shared_port_in
);

  localparam logic [`OCD_CNT_W-1:0] LONG_LD = `OCD_CNT_W'(LONG_HOLD_CYC - 1);
  localparam logic [`OCD_CNT_W-1:0] SHORT_LD = `OCD_CNT_W'(SHORT_HOLD_CYC - 1);

  ocd_state_t s;
  ocd_state_t next_s;
  ocd_cfg_t dc;
  logic spd;
  logic ren;
  logic cpb;
  logic wde;
  logic [2:0] osc_code;
  logic restart_wr;

  // Active fields of whichever variant is selected.
  always_comb begin
    if (s.variant) begin
      spd = s.large_w[`OCD_L_SPD];
      ren = s.large_w[`OCD_L_RST];
      cpb = s.large_w[`OCD_L_CP];
      wde = s.large_w[`OCD_L_WDT];
      osc_code = s.large_w[`OCD_L_OSC_HI:0];
    end else begin
      spd = s.small_w[`OCD_S_SPD];
      ren = s.small_w[`OCD_S_RST];
      cpb = s.small_w[`OCD_S_CP];
      wde = s.small_w[`OCD_S_WDT];
      osc_code = {1'b0, s.small_w[`OCD_S_OSC_HI:0]};
    end
  end

  // Decode of the active setup word.
  always_comb begin
    dc.speed_8mhz = spd;
    dc.ext_reset_en = ren;
    dc.protect_on = !cpb;
    dc.watchdog_on = wde;
    dc.instruction_clock_output_on = 1'b0;
    dc.long_hold = 1'b0;
    dc.osc_src = OCD_OSC_INT;
    if (!s.variant) begin
      case (osc_code)
        `OCD_SOSC_LP: begin
          dc.osc_src = OCD_OSC_LP;
          dc.long_hold = 1'b1;
        end
        `OCD_SOSC_XT: begin
          dc.osc_src = OCD_OSC_XT;
          dc.long_hold = 1'b1;
        end
        `OCD_SOSC_INT: dc.osc_src = OCD_OSC_INT;
        `OCD_SOSC_ERC: dc.osc_src = OCD_OSC_ERC;
        default: dc.osc_src = OCD_OSC_INT;
      endcase
    end else begin
      case (osc_code)
        `OCD_LOSC_LP: begin
          dc.osc_src = OCD_OSC_LP;
          dc.long_hold = 1'b1;
        end
        `OCD_LOSC_XT: begin
          dc.osc_src = OCD_OSC_XT;
          dc.long_hold = 1'b1;
        end
        `OCD_LOSC_HS: begin
          dc.osc_src = OCD_OSC_HS;
          dc.long_hold = 1'b1;
        end
        `OCD_LOSC_EC: dc.osc_src = OCD_OSC_EC;
        `OCD_LOSC_INT: dc.osc_src = OCD_OSC_INT;
        `OCD_LOSC_INTCK: begin
          dc.osc_src = OCD_OSC_INT;
          dc.instruction_clock_output_on = 1'b1;
        end
        `OCD_LOSC_ERC: dc.osc_src = OCD_OSC_ERC;
        `OCD_LOSC_ERCCK: begin
          dc.osc_src = OCD_OSC_ERC;
          dc.instruction_clock_output_on = 1'b1;
        end
        default: dc.osc_src = OCD_OSC_INT;
      endcase
    end
  end

  // Bus slave, register file and hold timer.
  always_comb begin
    next_s = s;
    restart_wr = 1'b0;
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_have = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_have = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wlane0 = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_have && next_s.w_have && !next_s.bvalid) begin
      next_s.aw_have = 1'b0;
      next_s.w_have = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `OCD_RESP_OKAY;
      case (next_s.awaddr)
        `OCD_REG_SMALL: begin
          if (next_s.wlane0) begin
            next_s.small_w = next_s.wdata[`OCD_S_SPD:0];
          end
        end
        `OCD_REG_LARGE: begin
          if (next_s.wlane0) begin
            next_s.large_w = next_s.wdata[`OCD_L_SPD:0];
          end
        end
        `OCD_REG_CTRL: begin
          if (next_s.wlane0) begin
            next_s.variant = next_s.wdata[`OCD_CTRL_VAR];
            restart_wr = next_s.wdata[`OCD_CTRL_RESTART];
          end
        end
        `OCD_REG_STAT: next_s.bresp = `OCD_RESP_OKAY;
        default: next_s.bresp = `OCD_RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_have && !next_s.bvalid;
    next_s.wready = !next_s.w_have && !next_s.bvalid;
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.raddr = s_axi_araddr;
      next_s.rresp = `OCD_RESP_OKAY;
      case (s_axi_araddr)
        `OCD_REG_SMALL: next_s.rdata = `OCD_SMALL_ONES | 32'(s.small_w);
        `OCD_REG_LARGE: next_s.rdata = `OCD_LARGE_ONES | 32'(s.large_w);
        `OCD_REG_CTRL: next_s.rdata = 32'(s.variant);
        `OCD_REG_STAT: next_s.rdata = 32'({s.hold_active, s.cfg});
        default: begin
          next_s.rdata = '0;
          next_s.rresp = `OCD_RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
    case (s.st)
      OCD_ST_RESTART: begin
        next_s.cnt = dc.long_hold ? LONG_LD : SHORT_LD;
        next_s.st = OCD_ST_HOLD;
      end
      OCD_ST_HOLD: begin
        if (s.cnt == '0) begin
          next_s.st = OCD_ST_RUN;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      OCD_ST_RUN: begin
        if (restart_wr) begin
          next_s.st = OCD_ST_RESTART;
        end
      end
      default: next_s.st = OCD_ST_RESTART;
    endcase
    next_s.cfg = dc;
    next_s.hold_active = next_s.st != OCD_ST_RUN;
    next_s.device_reset = next_s.hold_active || (dc.ext_reset_en && !external_reset_input_n);
    next_s.port_in = dc.ext_reset_en ? 1'b0 : external_reset_input_n;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.st <= OCD_ST_RESTART;
      s.small_w <= `OCD_SMALL_RST;
      s.large_w <= `OCD_LARGE_RST;
      s.hold_active <= 1'b1;
      s.device_reset <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign cfg = s.cfg;
  assign hold_active = s.hold_active;
  assign device_reset = s.device_reset;
  assign shared_port_in = s.port_in;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // The edge that releases reset still loads reset values, so decode checks start one edge later.
  a_small_upper_ones: assert property (
    s_axi_rvalid && s.raddr == `OCD_REG_SMALL
    |-> (s_axi_rdata & `OCD_SMALL_ONES) == `OCD_SMALL_ONES)
    else $error("Small word upper bits not read as one.");
  a_large_upper_ones: assert property (
    s_axi_rvalid && s.raddr == `OCD_REG_LARGE
    |-> (s_axi_rdata & `OCD_LARGE_ONES) == `OCD_LARGE_ONES)
    else $error("Large word upper bits not read as one.");
  a_speed_select: assert property (
    resetn |=> cfg.speed_8mhz == $past(spd))
    else $error("Speed select not decoded.");
  a_pin_reset_off: assert property (
    s.st == OCD_ST_RUN && !cfg.ext_reset_en |-> !device_reset)
    else $error("Reset asserted while pin is a port.");
  a_pin_reset_on: assert property (
    ren && !external_reset_input_n && s.st == OCD_ST_RUN |=> device_reset)
    else $error("Pin reset not honoured.");
  a_protect_low: assert property (
    resetn |=> cfg.protect_on != $past(cpb))
    else $error("Protection polarity wrong.");
  a_wdt_follows: assert property (
    resetn |=> cfg.watchdog_on == $past(wde))
    else $error("Watchdog enable not decoded.");
  a_small_crystal: assert property (
    resetn && !s.variant && osc_code[1] == 1'b0
    |=> cfg.long_hold && (cfg.osc_src == OCD_OSC_LP || cfg.osc_src == OCD_OSC_XT))
    else $error("Small crystal mode wrong.");
  a_small_rc: assert property (
    resetn && !s.variant && osc_code[1]
    |=> !cfg.long_hold && (cfg.osc_src == OCD_OSC_INT || cfg.osc_src == OCD_OSC_ERC))
    else $error("Small RC mode wrong.");
  a_large_int_port: assert property (
    resetn && s.variant && osc_code == `OCD_LOSC_INT
    |=> cfg.osc_src == OCD_OSC_INT && !cfg.instruction_clock_output_on && !cfg.long_hold)
    else $error("Large code 100 wrong.");
  a_large_int_instruction_clock_output: assert property (
    resetn && s.variant && osc_code == `OCD_LOSC_INTCK
    |=> cfg.osc_src == OCD_OSC_INT && cfg.instruction_clock_output_on && !cfg.long_hold)
    else $error("Large code 101 wrong.");
  a_large_rc_port: assert property (
    resetn && s.variant && osc_code == `OCD_LOSC_ERC
    |=> cfg.osc_src == OCD_OSC_ERC && !cfg.instruction_clock_output_on && !cfg.long_hold)
    else $error("Large code 110 wrong.");
  a_small_fields: assert property (
    resetn && !s.variant
    |=> cfg.speed_8mhz == $past(s.small_w[`OCD_S_SPD])
        && cfg.ext_reset_en == $past(s.small_w[`OCD_S_RST])
        && cfg.watchdog_on == $past(s.small_w[`OCD_S_WDT]))
    else $error("Small field positions wrong.");
  a_large_fields: assert property (
    resetn && s.variant
    |=> cfg.speed_8mhz == $past(s.large_w[`OCD_L_SPD])
        && cfg.ext_reset_en == $past(s.large_w[`OCD_L_RST])
        && cfg.watchdog_on == $past(s.large_w[`OCD_L_WDT]))
    else $error("Large field positions wrong.");
  a_large_others: assert property (
    resetn && s.variant && osc_code <= `OCD_LOSC_HS |=> cfg.long_hold && !cfg.instruction_clock_output_on)
    else $error("Large crystal mode wrong.");

  sequence q_restart;
    resetn && s.st == OCD_ST_RESTART;
  endsequence
  sequence q_loaded;
    s.st == OCD_ST_HOLD && (s.cnt == LONG_LD || s.cnt == SHORT_LD) && device_reset;
  endsequence
  sequence q_tick;
    s.st == OCD_ST_HOLD && s.cnt != '0;
  endsequence

  a_hold_load: assert property (
    q_restart |=> q_loaded)
    else $error("Hold interval not loaded.");
  a_hold_length: assert property (
    (q_restart and dc.long_hold) |=> s.cnt == LONG_LD)
    else $error("Crystal hold interval wrong.");
  a_hold_count: assert property (
    q_tick |=> s.st == OCD_ST_HOLD && s.cnt == $past(s.cnt) - 1'b1 && device_reset)
    else $error("Hold did not keep reset.");
  a_hold_exit: assert property (
    s.st == OCD_ST_HOLD && s.cnt == '0 |=> s.st == OCD_ST_RUN && !hold_active)
    else $error("Hold exit wrong.");
  a_wdt_static: assert property (
    $past(resetn, 2) && $changed(cfg.watchdog_on) |-> $past(wde) != $past(wde, 2))
    else $error("Watchdog changed without word change.");

endmodule : ocd_top

// *** testbench/ocd_top_tb.sv ***
// Self-checking bench for the setup word decoder and its start-up hold.
`timescale 1ns/1ps
`include "ocd_defs.svh"
module ocd_top_tb
  import ocd_pkg::*;
;
  localparam int LONG_N = 20;
  localparam int SHORT_N = 5;
  typedef struct packed {
    logic variant;
    logic [7:0] word;
    ocd_cfg_t exp;
  } ocd_row_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [4:0] s_axi_araddr = 5'h00;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic pin_n = 1'b1;
  ocd_cfg_t cfg;
  logic hold_active;
  logic device_reset;
  logic shared_port_in;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  int cnt;
  ocd_row_t rows [12] = '{
    '{1'b0, 8'h20, '{1'b1, 1'b0, 1'b1, 1'b0, OCD_OSC_LP, 1'b0, 1'b1}},
    '{1'b0, 8'h11, '{1'b0, 1'b1, 1'b1, 1'b0, OCD_OSC_XT, 1'b0, 1'b1}},
    '{1'b0, 8'h0E, '{1'b0, 1'b0, 1'b0, 1'b1, OCD_OSC_INT, 1'b0, 1'b0}},
    '{1'b0, 8'h3F, '{1'b1, 1'b1, 1'b0, 1'b1, OCD_OSC_ERC, 1'b0, 1'b0}},
    '{1'b1, 8'h40, '{1'b1, 1'b0, 1'b1, 1'b0, OCD_OSC_LP, 1'b0, 1'b1}},
    '{1'b1, 8'h21, '{1'b0, 1'b1, 1'b1, 1'b0, OCD_OSC_XT, 1'b0, 1'b1}},
    '{1'b1, 8'h12, '{1'b0, 1'b0, 1'b0, 1'b0, OCD_OSC_HS, 1'b0, 1'b1}},
    '{1'b1, 8'h0B, '{1'b0, 1'b0, 1'b1, 1'b1, OCD_OSC_EC, 1'b0, 1'b0}},
    '{1'b1, 8'h04, '{1'b0, 1'b0, 1'b1, 1'b0, OCD_OSC_INT, 1'b0, 1'b0}},
    '{1'b1, 8'h05, '{1'b0, 1'b0, 1'b1, 1'b0, OCD_OSC_INT, 1'b1, 1'b0}},
    '{1'b1, 8'h06, '{1'b0, 1'b0, 1'b1, 1'b0, OCD_OSC_ERC, 1'b0, 1'b0}},
    '{1'b1, 8'h7F, '{1'b1, 1'b1, 1'b0, 1'b1, OCD_OSC_ERC, 1'b1, 1'b0}}
  };

  always #4 mclk = ~mclk;

  ocd_top #(.LONG_HOLD_CYC(LONG_N), .SHORT_HOLD_CYC(SHORT_N)) ocd_top_i (
    .mclk(mclk), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .external_reset_input_n(pin_n), .cfg(cfg), .hold_active(hold_active),
    .device_reset(device_reset), .shared_port_in(shared_port_in)
  );

  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_cfg(input ocd_cfg_t got, input ocd_cfg_t exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: decode got %b expected %b", $time, got, exp);
    end
  endtask : cmp_cfg

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    r = 2'h1;
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (aw_done && w_done && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic a_done;
    a_done = 1'b0;
    d = 32'h0;
    r = 2'h1;
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (a_done && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (!a_done && s_axi_arready === 1'b1) begin
        a_done = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask : axi_rd

  // Counts the hold length and checks that reset is asserted all along.
  task automatic hold_len(input int n);
    int c;
    c = 0;
    while (hold_active === 1'b1 && c < 1000) begin
      cmp_bit(device_reset, 1'b1, "reset during hold");
      @(posedge mclk);
      c++;
    end
    cmp_bit(c == n, 1'b1, "hold length");
  endtask : hold_len

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (16) @(posedge mclk);
    cmp_bit(device_reset, 1'b1, "reset asserted");
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    hold_len(SHORT_N);
    axi_rd(`OCD_REG_SMALL, rd, resp);
    cmp_word(rd, 32'h0000FFFF, "small word reset");
    axi_rd(`OCD_REG_LARGE, rd, resp);
    cmp_word(rd, 32'h00000FFF, "large word reset");
    foreach (rows[i]) begin
      axi_wr(`OCD_REG_CTRL, {31'h0, rows[i].variant}, 4'hF, resp);
      axi_wr(rows[i].variant ? `OCD_REG_LARGE : `OCD_REG_SMALL, {24'h0, rows[i].word}, 4'hF,
             resp);
      repeat (2) @(posedge mclk);
      cmp_cfg(cfg, rows[i].exp);
      axi_rd(rows[i].variant ? `OCD_REG_LARGE : `OCD_REG_SMALL, rd, resp);
      cmp_word(rd, (rows[i].variant ? `OCD_LARGE_ONES : `OCD_SMALL_ONES) | rows[i].word,
               "word readback");
    end
    // Writes with lane 0 masked or to other addresses must not switch the watchdog off.
    axi_wr(`OCD_REG_LARGE, 32'h0, 4'hE, resp);
    axi_wr(`OCD_REG_STAT, 32'h0, 4'hF, resp);
    axi_wr(5'h10, 32'h0, 4'hF, resp);
    cmp_word({30'h0, resp}, {30'h0, `OCD_RESP_SLVERR}, "unmapped write response");
    axi_wr(5'h06, 32'h0, 4'hF, resp);
    repeat (2) @(posedge mclk);
    cmp_bit(cfg.watchdog_on, 1'b1, "watchdog kept on");
    axi_rd(5'h14, rd, resp);
    cmp_word({rd[29:0], resp}, {30'h0, `OCD_RESP_SLVERR}, "unmapped read");
    axi_rd(`OCD_REG_STAT, rd, resp);
    cmp_word(rd, {22'h0, 1'b0, rows[11].exp}, "status word");
    axi_wr(`OCD_REG_CTRL, 32'h0, 4'hF, resp);
    for (int k = 0; k < 4; k++) begin
      axi_wr(`OCD_REG_SMALL, {27'h0, k[1], 4'hE}, 4'hF, resp);
      pin_n <= k[0];
      repeat (3) @(posedge mclk);
      cmp_bit(device_reset, k[1] & ~k[0], "pin reset");
      cmp_bit(shared_port_in, k[1] ? 1'b0 : k[0], "port input");
    end
    pin_n <= 1'b1;
    axi_wr(`OCD_REG_SMALL, 32'h0, 4'hF, resp);
    axi_wr(`OCD_REG_CTRL, 32'h2, 4'hF, resp);
    @(posedge mclk);
    hold_len(LONG_N);
    cmp_bit(device_reset, 1'b0, "reset released");
    axi_wr(`OCD_REG_SMALL, 32'h0E, 4'hF, resp);
    axi_wr(`OCD_REG_CTRL, 32'h2, 4'hF, resp);
    @(posedge mclk);
    hold_len(SHORT_N);
    results();
  end
endmodule : ocd_top_tb
